//--- hdl/adcf_clk_div.sv
`timescale 1ns/1ps
// Conversion clock: one tick every div+1 system clocks while run is high
module adcf_clk_div (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic [4:0] div,
   // Tick out
   output logic            tick
);
   logic [4:0] cnt_reg;

   // Counter restarts whenever run drops so each conversion starts aligned
   always_ff @(posedge clock) begin
      if (rst || !run || tick) begin
         cnt_reg <= 5'h00;
      end else begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   assign tick = run && (cnt_reg == div);
endmodule // adcf_clk_div

//--- hdl/adcf_consts.svh
`ifndef ADCF_CONSTS_SVH
`define ADCF_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADCF_OFF_CTRL      8'h00
`define ADCF_OFF_CFG       8'h04
`define ADCF_OFF_POS       8'h08
`define ADCF_OFF_NEG       8'h0C
`define ADCF_OFF_RES_HI    8'h10
`define ADCF_OFF_RES_LO    8'h14
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCF_CTRL_EN_BIT   7
`define ADCF_CTRL_DONE_BIT 5
`define ADCF_CTRL_BUSY_BIT 4
`define ADCF_CTRL_LJ_BIT   0
`define ADCF_CFG_DIV_LSB   3
`define ADCF_CFG_DIV_MSB   7
// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define ADCF_DIV_RESET     5'h1F
`define ADCF_SEL_RESET     5'h00
`define ADCF_NEG_GND       5'h1F
`define ADCF_NEG_VREF      5'h1E
`define ADCF_POS_TEMP      5'h1E
`define ADCF_POS_SUPPLY    5'h1F
`define ADCF_SAR_FIRST     10'h200
`define ADCF_SAR_TOP_IDX   4'h9
`define ADCF_LJ_SHIFT      6
`endif

//--- hdl/adcf_format.sv
`timescale 1ns/1ps
`include "adcf_consts.svh"
// Places a 10-bit code into the 16-bit result pair
module adcf_format (
   // Inputs
   input  wire logic [9:0]  code,
   input  wire logic        diff,
   input  wire logic        ljst,
   // Result pair
   output logic      [15:0] result
);
   logic fill;

   // Upper fill is the sign only for right-justified differential data
   assign fill = diff & ~ljst & code[9]; // RL10

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_bit
         if (i < `ADCF_LJ_SHIFT) begin : g_lo
            assign result[i] = ljst ? 1'b0 : code[i]; // RL8 RL11 RL15
         end else if (i < 10) begin : g_mid
            assign result[i] = ljst ? code[i-`ADCF_LJ_SHIFT] : code[i]; // RL6 RL7
         end else begin : g_hi
            assign result[i] = ljst ? code[i-`ADCF_LJ_SHIFT] : fill;
         end
      end
   endgenerate
endmodule // adcf_format

//--- hdl/adcf_pkg.sv
package adcf_pkg;
   // Conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_TRACK   = 2'b01,
      ST_CONVERT = 2'b10,
      ST_FINISH  = 2'b11
   } adcf_state_t;
endpackage

//--- hdl/adcf_top.sv
`timescale 1ns/1ps
`include "adcf_consts.svh"
// Overview of operation
// RL1: The converter only runs while the subsystem enable bit is 1.
// RL2: With the enable bit at 0 the converter sits powered down and does no conversion.
// RL3: Ground as negative input means single-ended mode, any other negative input means differential.
// RL4: Positive input picks port pins, temperature sensor or supply; negative picks port pins, reference or ground.
// RL5: Every finished conversion loads the result high and low bytes.
// RL6: Control bit 0 picks right (0) or left (1) justification.
// RL7: Single-ended codes are 10-bit unsigned, full scale 0x03FF right or 0xFFC0 left.
// RL8: In single-ended mode all unused result bits read zero.
// RL9: Differential codes are 10-bit two's complement, minus full scale 0xFE00 right or 0x8000 left.
// RL10: Right-justified differential results sign-extend into the high byte.
// RL11: Left-justified differential results have zero low bits.
// RL12: Software sets converter pins to analog mode and makes the crossbar skip them.
// RL13: The busy bit is 1 during a conversion and its fall sets the done flag; on an abort by clearing enable, busy falls without setting it.
// RL14: The conversion clock is the system clock divided by the divide field plus one.
// RL15: A left-justified result is the code shifted up six places with the low six bits zero.
module adcf_top (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   // Analog core
   input  wire logic        cmp_in,
   output logic      [9:0]  dac_code,
   output logic             hold,
   output logic             power_down,
   output logic      [4:0]  positive_input,
   output logic      [4:0]  negative_input,
   output logic             diff_mode
);
   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   adcf_pkg::adcf_state_t state_reg;
   adcf_pkg::adcf_state_t state_next;
   logic        subsystem_enable_bit_reg;
   logic        left_justify_bit_reg;
   logic        conversion_done_flag_reg;
   logic        conversion_in_progress_bit_reg;
   logic [4:0]  clock_divide_field_reg;
   logic [4:0]  positive_select_reg;
   logic [4:0]  negative_select_reg;
   logic [7:0]  result_high_byte_reg;
   logic [7:0]  result_low_byte_reg;
   logic [9:0]  trial_reg;
   logic [3:0]  idx_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [31:0] rd_next;
   logic        rd_err;
   logic        wr_en;
   logic        access;
   logic        start;
   logic        tick;
   logic        run;
   logic        is_diff;
   logic [9:0]  code;
   logic [15:0] formatted;
   logic [9:0]  decided;

   // -------------------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------------------
   // One wait state: ready goes high on the second access cycle
   assign access = psel && penable && !pready_reg;
   assign wr_en  = psel && penable && pready_reg && pwrite && !pslverr_reg;

   // Read mux and unmapped-address decode
   always_comb begin
      rd_next = 32'h0000_0000;
      rd_err  = 1'b0;
      unique case (paddr)
         `ADCF_OFF_CTRL: begin
            rd_next[`ADCF_CTRL_EN_BIT]   = subsystem_enable_bit_reg;
            rd_next[`ADCF_CTRL_DONE_BIT] = conversion_done_flag_reg;
            rd_next[`ADCF_CTRL_BUSY_BIT] = conversion_in_progress_bit_reg; // RL13
            rd_next[`ADCF_CTRL_LJ_BIT]   = left_justify_bit_reg;
         end
         `ADCF_OFF_CFG:    rd_next[`ADCF_CFG_DIV_MSB:`ADCF_CFG_DIV_LSB] = clock_divide_field_reg;
         `ADCF_OFF_POS:    rd_next[4:0] = positive_select_reg;
         `ADCF_OFF_NEG:    rd_next[4:0] = negative_select_reg;
         `ADCF_OFF_RES_HI: rd_next[7:0] = result_high_byte_reg;
         `ADCF_OFF_RES_LO: rd_next[7:0] = result_low_byte_reg;
         default:          rd_err = 1'b1;
      endcase
   end

   // Answer registers; read data is captured while the address is stable
   always_ff @(posedge clock) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= access;
         pslverr_reg <= access && rd_err;
         if (access && !pwrite) begin
            prdata_reg <= rd_next;
         end else if (!psel) begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // -------------------------------------------------------------------------
   // Software-written control
   // -------------------------------------------------------------------------
   // A start is a write of 1 to the busy bit while enabled and idle
   assign start = wr_en && (paddr == `ADCF_OFF_CTRL) && pwdata[`ADCF_CTRL_BUSY_BIT]
                  && pwdata[`ADCF_CTRL_EN_BIT] && subsystem_enable_bit_reg
                  && (state_reg == adcf_pkg::ST_IDLE);

   // Control bits
   always_ff @(posedge clock) begin
      if (rst) begin
         subsystem_enable_bit_reg <= 1'b0;
         left_justify_bit_reg     <= 1'b0;
      end else if (wr_en && (paddr == `ADCF_OFF_CTRL)) begin
         subsystem_enable_bit_reg <= pwdata[`ADCF_CTRL_EN_BIT]; // RL1
         left_justify_bit_reg     <= pwdata[`ADCF_CTRL_LJ_BIT]; // RL6
      end
   end

   // Divider is locked while a conversion runs so the tick period stays fixed
   always_ff @(posedge clock) begin
      if (rst) begin
         clock_divide_field_reg <= `ADCF_DIV_RESET;
      end else if (wr_en && (paddr == `ADCF_OFF_CFG) && !conversion_in_progress_bit_reg) begin
         clock_divide_field_reg <= pwdata[`ADCF_CFG_DIV_MSB:`ADCF_CFG_DIV_LSB];
      end
   end

   // Input selections
   always_ff @(posedge clock) begin
      if (rst) begin
         positive_select_reg <= `ADCF_SEL_RESET;
         negative_select_reg <= `ADCF_SEL_RESET;
      end else begin
         if (wr_en && (paddr == `ADCF_OFF_POS)) begin
            positive_select_reg <= pwdata[4:0]; // RL4
         end
         if (wr_en && (paddr == `ADCF_OFF_NEG)) begin
            negative_select_reg <= pwdata[4:0]; // RL4
         end
      end
   end

   // Done flag: hardware set wins over a software write of 0 in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         conversion_done_flag_reg <= 1'b0;
      end else if (state_reg == adcf_pkg::ST_FINISH) begin
         conversion_done_flag_reg <= 1'b1; // RL13
      end else if (wr_en && (paddr == `ADCF_OFF_CTRL) && !pwdata[`ADCF_CTRL_DONE_BIT]) begin
         conversion_done_flag_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Conversion sequencer
   // -------------------------------------------------------------------------
   assign run     = (state_reg == adcf_pkg::ST_TRACK) || (state_reg == adcf_pkg::ST_CONVERT);
   assign is_diff = (negative_select_reg != `ADCF_NEG_GND); // RL3

   adcf_clk_div u_div (
      .clock (clock),
      .rst   (rst),
      .run   (run),
      .div   (clock_divide_field_reg), // RL14
      .tick  (tick)
   );

   // Next state; dropping the enable aborts at once
   always_comb begin
      state_next = state_reg;
      if (!subsystem_enable_bit_reg) begin
         state_next = adcf_pkg::ST_IDLE; // RL2
      end else begin
         unique case (state_reg)
            adcf_pkg::ST_IDLE:    if (start) state_next = adcf_pkg::ST_TRACK;
            adcf_pkg::ST_TRACK:   if (tick) state_next = adcf_pkg::ST_CONVERT;
            adcf_pkg::ST_CONVERT: if (tick && idx_reg == 4'h0) state_next = adcf_pkg::ST_FINISH;
            adcf_pkg::ST_FINISH:  state_next = adcf_pkg::ST_IDLE;
         endcase
      end
   end

   // State and busy bit
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg                      <= adcf_pkg::ST_IDLE;
         conversion_in_progress_bit_reg <= 1'b0;
      end else begin
         state_reg                      <= state_next;
         // Busy covers the load cycle so its fall lines up with the done flag
         conversion_in_progress_bit_reg <= (state_next != adcf_pkg::ST_IDLE); // RL13
      end
   end

   // Current trial with the bit under test decided by the comparator
   assign decided = cmp_in ? trial_reg : (trial_reg & ~(10'h001 << idx_reg));

   // Successive approximation, one bit per conversion clock, MSB first
   always_ff @(posedge clock) begin
      if (rst) begin
         trial_reg <= 10'h000;
         idx_reg   <= 4'h0;
      end else if (state_reg == adcf_pkg::ST_TRACK && tick) begin
         trial_reg <= `ADCF_SAR_FIRST;
         idx_reg   <= `ADCF_SAR_TOP_IDX;
      end else if (state_reg == adcf_pkg::ST_CONVERT && tick) begin
         if (idx_reg == 4'h0) begin
            trial_reg <= decided;
         end else begin
            trial_reg <= decided | (10'h001 << (idx_reg - 4'h1));
            idx_reg   <= idx_reg - 4'h1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Result formatting and load
   // -------------------------------------------------------------------------
   // Offset binary from the array becomes two's complement in differential mode
   assign code = is_diff ? (trial_reg ^ `ADCF_SAR_FIRST) : trial_reg; // RL9

   adcf_format u_fmt (
      .code   (code),
      .diff   (is_diff),
      .ljst   (left_justify_bit_reg),
      .result (formatted)
   );

   // Result pair loads only when a conversion completes
   always_ff @(posedge clock) begin
      if (rst) begin
         result_high_byte_reg <= 8'h00;
         result_low_byte_reg  <= 8'h00;
      end else if (state_reg == adcf_pkg::ST_FINISH) begin
         result_high_byte_reg <= formatted[15:8]; // RL5
         result_low_byte_reg  <= formatted[7:0]; // RL5
      end
   end

   // -------------------------------------------------------------------------
   // Analog core drive
   // -------------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         dac_code       <= 10'h000;
         hold           <= 1'b0;
         power_down     <= 1'b1;
         positive_input <= `ADCF_SEL_RESET;
         negative_input <= `ADCF_SEL_RESET;
         diff_mode      <= 1'b0;
      end else begin
         dac_code       <= trial_reg;
         hold           <= (state_next == adcf_pkg::ST_CONVERT);
         power_down     <= !subsystem_enable_bit_reg; // RL2
         positive_input <= positive_select_reg; // RL4
         negative_input <= negative_select_reg; // RL4
         diff_mode      <= is_diff; // RL3
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   logic [5:0] gap_cnt;

   // Cycles since the last conversion clock tick
   always_ff @(posedge clock) begin
      if (rst || !run || tick) begin
         gap_cnt <= 6'h00;
      end else begin
         gap_cnt <= gap_cnt + 6'h01;
      end
   end

   property p_off_idle;
      @(posedge clock) disable iff (rst) !subsystem_enable_bit_reg |=> state_reg == adcf_pkg::ST_IDLE;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("converter active while disabled"); // RL1

   property p_off_quiet;
      @(posedge clock) disable iff (rst) !subsystem_enable_bit_reg ##1 !subsystem_enable_bit_reg
         |=> power_down && !conversion_in_progress_bit_reg && !hold;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled converter not shut down"); // RL2

   property p_mode;
      @(posedge clock) disable iff (rst) 1'b1 |=> diff_mode == ($past(negative_select_reg) != `ADCF_NEG_GND);
   endproperty
   a_mode: assert property (p_mode) else $error("mode does not follow negative select"); // RL3

   property p_load;
      @(posedge clock) disable iff (rst) state_reg == adcf_pkg::ST_FINISH
         |=> {result_high_byte_reg, result_low_byte_reg} == $past(formatted) && conversion_done_flag_reg;
   endproperty
   a_load: assert property (p_load) else $error("result not loaded at completion"); // RL5

   property p_se_zero;
      @(posedge clock) disable iff (rst) state_reg == adcf_pkg::ST_FINISH && !is_diff
         |=> (left_justify_bit_reg ? result_low_byte_reg[5:0] == 6'h00 : result_high_byte_reg[7:2] == 6'h00);
   endproperty
   a_se_zero: assert property (p_se_zero) else $error("single-ended unused bits not zero"); // RL8

   property p_sext;
      @(posedge clock) disable iff (rst) state_reg == adcf_pkg::ST_FINISH && is_diff && !left_justify_bit_reg
         |=> result_high_byte_reg[7:2] == {6{result_high_byte_reg[1]}};
   endproperty
   a_sext: assert property (p_sext) else $error("right-justified sign extension wrong"); // RL10

   property p_lj;
      @(posedge clock) disable iff (rst) state_reg == adcf_pkg::ST_FINISH && left_justify_bit_reg
         |=> {result_high_byte_reg, result_low_byte_reg} == {$past(code), 6'h00};
   endproperty
   a_lj: assert property (p_lj) else $error("left-justified layout wrong"); // RL15

   property p_done;
      @(posedge clock) disable iff (rst) $fell(conversion_in_progress_bit_reg) && subsystem_enable_bit_reg
         |-> conversion_done_flag_reg;
   endproperty
   a_done: assert property (p_done) else $error("busy fell without done flag"); // RL13

   property p_start;
      @(posedge clock) disable iff (rst) start |=> conversion_in_progress_bit_reg [*2];
   endproperty
   a_start: assert property (p_start) else $error("start did not raise busy"); // RL13

   property p_div;
      @(posedge clock) disable iff (rst) tick |-> gap_cnt == {1'b0, clock_divide_field_reg};
   endproperty
   a_div: assert property (p_div) else $error("conversion clock period wrong"); // RL14

   property p_apb_wait;
      @(posedge clock) disable iff (rst) psel && penable && !pready |=> pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

   c_se_done: cover property (@(posedge clock) disable iff (rst)
      state_reg == adcf_pkg::ST_FINISH && !is_diff);
   c_diff_lj: cover property (@(posedge clock) disable iff (rst)
      state_reg == adcf_pkg::ST_FINISH && is_diff && left_justify_bit_reg);
   c_abort: cover property (@(posedge clock) disable iff (rst)
      conversion_in_progress_bit_reg && !subsystem_enable_bit_reg);
endmodule // adcf_top

//--- tb/adcf_tb.sv
`timescale 1ns/1ps
`include "adcf_consts.svh"
module tb;
   // ------------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------------
   logic        clock;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        cmp_in = 1'b0;
   logic [9:0]  dac_code;
   logic        hold;
   logic        power_down;
   logic [4:0]  positive_input;
   logic [4:0]  negative_input;
   logic        diff_mode;
   logic [9:0]  vin;
   int          err_count;
   int          comparisons;
   int          hold_cnt = 0;
   int          hold_base;
   logic [31:0] r;
   logic [31:0] r2;
   logic        e;
   logic [15:0] res;
   logic [4:0]  neg_tab [9] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1E, 5'h1E, 5'h03, 5'h03, 5'h1E};
   logic        lj_tab  [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [9:0]  vin_tab [9] = '{10'h3FF, 10'h3FF, 10'h200, 10'h000, 10'h000, 10'h000, 10'h3FF, 10'h3FF, 10'h100};
   logic [15:0] exp_tab [9] = '{16'h03FF, 16'hFFC0, 16'h8000, 16'h0000, 16'hFE00, 16'h8000, 16'h01FF, 16'h7FC0,
                                16'hFF00};
   logic [4:0]  mode_tab [3] = '{5'h1F, 5'h1E, 5'h03};
   logic [4:0]  pos_tab  [3] = '{5'h1E, 5'h1F, 5'h05};

   // ------------------------------------------------------------------------
   // Device under test
   // ------------------------------------------------------------------------
   adcf_top i_dut (
      .clock          (clock),
      .rst            (rst),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .pready         (pready),
      .prdata         (prdata),
      .pslverr        (pslverr),
      .cmp_in         (cmp_in),
      .dac_code       (dac_code),
      .hold           (hold),
      .power_down     (power_down),
      .positive_input (positive_input),
      .negative_input (negative_input),
      .diff_mode      (diff_mode)
   );

   // Free-running system clock, 4 ns period
   initial clock = 1'b0;
   always #2 clock = ~clock;

   // Ideal comparator; one cycle of lag is harmless with the slow default divide
   always @(posedge clock) begin
      cmp_in <= (vin >= dac_code);
      if (hold === 1'b1) hold_cnt <= hold_cnt + 1;
   end

   // ------------------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic hang(input string what);
      err_count++;
      $display("CHECK FAILED at %0t: %s did not finish", $time, what);
      conclude();
   endtask

   // ------------------------------------------------------------------------
   // APB master; one idle edge first so no signal is driven twice in a step
   // ------------------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) hang("apb transfer");
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      logic        de;
      apb(1'b1, a, d, dummy, de);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic de;
      apb(1'b0, a, 32'h0, d, de);
   endtask

   // Enable, start, poll busy, then fetch the result pair
   task automatic conv(input logic [9:0] v, input logic lj, output logic [15:0] rs);
      logic [31:0] c;
      logic [31:0] h;
      int          n;
      vin      <= v;
      hold_base = hold_cnt;
      wr(`ADCF_OFF_CTRL, 32'h80 | {31'h0, lj});
      wr(`ADCF_OFF_CTRL, 32'h90 | {31'h0, lj});
      n = 0;
      c = 32'h10;
      while (c[4] !== 1'b0 && n < 200) begin
         rd(`ADCF_OFF_CTRL, c);
         n++;
      end
      if (c[4] !== 1'b0) hang("conversion");
      chk(c & 32'hB1, 32'hA0 | {31'h0, lj}, "control after conversion");
      rd(`ADCF_OFF_RES_HI, h);
      rd(`ADCF_OFF_RES_LO, c);
      rs = {h[7:0], c[7:0]};
   endtask

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      vin = 10'h000;
      hold_base = 0;
      err_count = 0;
      comparisons = 0;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      // Reset state and an unmapped address
      rd(`ADCF_OFF_CTRL, r);
      chk(r & 32'hB1, 32'h0, "control reset");
      chk(power_down, 1'b1, "shutdown after reset");
      rd(`ADCF_OFF_CFG, r);
      chk(r & 32'hF8, 32'hF8, "divide reset");
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk({31'h0, e}, 32'h1, "unmapped error flag");
      chk(r, 32'h0, "unmapped read data");
      $display("test reset done");
      // A start while disabled must be ignored
      wr(`ADCF_OFF_CTRL, 32'h10);
      repeat (4) @(posedge clock);
      chk(hold, 1'b0, "no decision while disabled");
      rd(`ADCF_OFF_CTRL, r);
      chk(r & 32'hB1, 32'h0, "start ignored while disabled");
      chk(power_down, 1'b1, "still shut down");
      $display("test disabled done");
      // Mode follows the negative selection; selects reach the core
      for (int i = 0; i < 3; i++) begin
         wr(`ADCF_OFF_NEG, {27'h0, mode_tab[i]});
         wr(`ADCF_OFF_POS, {27'h0, pos_tab[i]});
         repeat (3) @(posedge clock);
         chk(diff_mode, (mode_tab[i] != 5'h1F), "mode");
         chk(negative_input, mode_tab[i], "negative select");
         chk(positive_input, pos_tab[i], "positive select");
      end
      $display("test modes done");
      // Codes across both modes and both alignments
      for (int i = 0; i < 9; i++) begin
         wr(`ADCF_OFF_NEG, {27'h0, neg_tab[i]});
         conv(vin_tab[i], lj_tab[i], res);
         chk(res, exp_tab[i], "result pair");
         chk(dac_code, {22'h0, vin_tab[i]}, "array code after conversion");
         if (i == 0) chk(hold_cnt - hold_base, 32'd320, "decision cycles at divide 31");
         if (i == 0) chk(power_down, 1'b0, "powered while enabled");
      end
      $display("test codes done");
      // Clearing enable mid-conversion aborts without a load
      vin <= 10'h155;
      wr(`ADCF_OFF_CTRL, 32'h80);
      wr(`ADCF_OFF_CTRL, 32'h90);
      repeat (60) @(posedge clock);
      wr(`ADCF_OFF_CTRL, 32'h00);
      repeat (2) @(posedge clock);
      chk(hold, 1'b0, "decisions stopped");
      chk(power_down, 1'b1, "shut down on abort");
      rd(`ADCF_OFF_CTRL, r);
      chk(r & 32'hB1, 32'h0, "no busy, no done after abort");
      rd(`ADCF_OFF_RES_HI, r);
      rd(`ADCF_OFF_RES_LO, r2);
      chk({r[7:0], r2[7:0]}, 16'hFF00, "result kept after abort");
      $display("test abort done");
      // Fastest divide: one decision per system clock
      wr(`ADCF_OFF_CFG, 32'h0);
      conv(10'h2AA, 1'b0, res);
      chk(hold_cnt - hold_base, 32'd10, "decision cycles at divide 0");
      $display("test divide done");
      conclude();
   end
endmodule // tb
